// ==== bench/encoder_model.sv ====
// Motor position encoder model: integrates a per-cycle step into a position count
`timescale 1ns/1ns
`include "sdm_cfg.svh"

module encoder_model (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Async reset, active high
	input wire logic signed [`SDM_POS_W-1:0] step_i, // Increments per cycle
	output logic signed [`SDM_POS_W-1:0] pos_o // Position count
);
	// Nonzero start so the reference load at monitoring start is visible
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pos_o <= 32'h0000_0500;
		end else begin
			pos_o <= pos_o + step_i;
		end
	end
endmodule : encoder_model

// ==== bench/testbench.sv ====
// Self-checking bench for the safe direction monitor
`timescale 1ns/1ns
`include "sdm_cfg.svh"
`define CHK(got, exp) check_val(got, exp)

module testbench;
	import direction_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic arm_low = 1'b1;
	logic signed [`SDM_POS_W-1:0] step = 32'h0000_0000;
	logic signed [`SDM_POS_W-1:0] pos;
	cfg_s cfg;
	logic ack;
	logic estop;
	status_s st;
	int error_cnt = 0;
	int check_count = 0;
	int cycles = 0;

	always #10 clk_i = ~clk_i;

	encoder_model enc (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .pos_o(pos));
	safe_direction_monitor #(.CYC_PER_MS(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .arm_input_low_i(arm_low),
		.pos_i(pos), .cfg_i(cfg), .dir_ack_o(ack), .estop_ramp_request_o(estop), .status_o(st));

	// Compared word is {ack, stop request, monitoring, violation}
	task check_val(input logic [3:0] got, input logic [3:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check_val

	task tick(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask : tick

	task set_arm(input logic v);
		@(posedge clk_i);
		arm_low <= v;
	endtask : set_arm

	// Steps of d for n cycles, then a few idle cycles for the monitor to react
	task move(input logic signed [`SDM_POS_W-1:0] d, input int n);
		@(posedge clk_i);
		step <= d;
		repeat (n) @(posedge clk_i);
		step <= 32'h0000_0000;
		tick(4);
	endtask : move

	task finish_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	// Whole run needs about two hundred cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			finish_test();
		end
	end

	initial begin
		cfg = '0;
		cfg.delay_ms = 17'h0_0002;
		cfg.window = `SDM_WINDOW_DEF;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(1);
		`CHK({ack, estop, st}, 4'h0);
		set_arm(1'b0);
		tick(12);
		`CHK({ack, estop, st}, 4'h0);
		tick(1);
		`CHK({ack, estop, st}, 4'ha);
		$display("test start_delay done");
		move(32'hFFFF_FFF6, 40);
		`CHK({ack, estop, st}, 4'ha);
		move(32'h0000_000A, 10);
		`CHK({ack, estop, st}, 4'ha);
		move(32'h0000_0001, 1);
		`CHK({ack, estop, st}, 4'h7);
		move(32'hFFFF_FFF6, 5);
		`CHK({ack, estop, st}, 4'h6);
		set_arm(1'b1);
		tick(3);
		`CHK({ack, estop, st}, 4'h0);
		$display("test negative_window done");
		@(posedge clk_i);
		cfg.dir_positive <= 1'b1;
		cfg.monitor_only <= 1'b1;
		cfg.delay_ms <= `SDM_MS_ZERO;
		cfg.hyst_en <= 1'b1;
		cfg.hyst <= 31'h0000_0014;
		set_arm(1'b0);
		tick(6);
		`CHK({ack, estop, st}, 4'ha);
		move(32'h0000_000A, 20);
		`CHK({ack, estop, st}, 4'ha);
		move(32'hFFFF_FFF6, 10);
		`CHK({ack, estop, st}, 4'ha);
		move(32'hFFFF_FFFF, 1);
		`CHK({ack, estop, st}, 4'h3);
		move(32'h0000_0001, 15);
		`CHK({ack, estop, st}, 4'h3);
		move(32'h0000_0001, 6);
		`CHK({ack, estop, st}, 4'ha);
		$display("test monitor_only_hysteresis done");
		set_arm(1'b1);
		tick(3);
		`CHK({ack, estop, st}, 4'h0);
		@(posedge clk_i);
		cfg.delay_ms <= 17'h0_0002;
		cfg.permanent <= 1'b1;
		tick(2);
		`CHK({ack, estop, st}, 4'ha);
		$display("test permanent done");
		finish_test();
	end
endmodule : testbench

// ==== hw/direction_pkg.sv ====
// Types shared by the safe direction monitor and its delay timer
`include "sdm_cfg.svh"

package direction_pkg;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_DELAY,
		PH_MONITOR
	} phase_e;

	typedef struct packed {
		logic permanent;
		logic dir_positive;
		logic monitor_only;
		logic [`SDM_DELAY_W-1:0] delay_ms;
		logic [`SDM_WIN_W-1:0] window;
		logic hyst_en;
		logic [`SDM_WIN_W-1:0] hyst;
	} cfg_s;

	typedef struct packed {
		logic monitoring;
		logic violation;
	} status_s;

	typedef struct packed {
		logic [1:0] arm_sync;
		phase_e phase;
		logic signed [`SDM_POS_W-1:0] trail_pos;
		logic viol;
		logic estop;
		logic ack;
	} mon_state_s;

	typedef struct packed {
		logic [`SDM_PRESC_W-1:0] presc;
		logic [`SDM_DELAY_W-1:0] ms;
		logic done;
	} timer_state_s;

endpackage : direction_pkg

// ==== hw/ms_delay_timer.sv ====
// Millisecond delay timer for the monitoring start delay
`timescale 1ns/1ns
`include "sdm_cfg.svh"

module ms_delay_timer #(
	parameter int CYC_PER_MS = `SDM_CLK_HZ / `SDM_MS_PER_S
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Async reset, active high
	input wire logic run_i, // Count while high, clear when low
	input wire logic [`SDM_DELAY_W-1:0] delay_ms_i, // Delay in ms
	output logic done_o // High once delay has elapsed
);
	import direction_pkg::*;

	timer_state_s st;
	timer_state_s next_st;

	always_comb begin
		next_st = st;
		if (!run_i) begin
			next_st.presc = `SDM_PRESC_ZERO;
			next_st.ms = `SDM_MS_ZERO;
			next_st.done = 1'b0;
		end else if (st.ms >= delay_ms_i) begin
			next_st.done = 1'b1;
		end else if (st.presc == `SDM_PRESC_W'(CYC_PER_MS - 1)) begin
			next_st.presc = `SDM_PRESC_ZERO;
			next_st.ms = st.ms + `SDM_MS_ONE;
		end else begin
			next_st.presc = st.presc + `SDM_PRESC_ONE;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done_o = st.done;

	// Done is low from the cycle after the timer is stopped
	AST_TMR_STOPPED: assert property (@(posedge clk_i) disable iff (rst_i)
		!run_i |=> !done_o) else $error("timer done while stopped");

endmodule : ms_delay_timer

// ==== hw/safe_direction_monitor.sv ====
// Safe direction monitor: one permitted direction, trailing window, stop request
`timescale 1ns/1ns
`include "sdm_cfg.svh"

module safe_direction_monitor #(
	parameter int CYC_PER_MS = `SDM_CLK_HZ / `SDM_MS_PER_S
) (
	input wire logic clk_i, // System clock, 50 MHz
	input wire logic rst_i, // Async reset, active high
	input wire logic arm_input_low_i, // Safe input pin, low arms
	input wire logic signed [`SDM_POS_W-1:0] pos_i, // Motor position, same clock
	input direction_pkg::cfg_s cfg_i, // Static configuration
	output logic dir_ack_o, // High while monitoring with no latched violation or stop request
	output logic estop_ramp_request_o, // Sticky stop ramp request
	output direction_pkg::status_s status_o // Monitoring and violation flags
);
	import direction_pkg::*;

	mon_state_s st;
	mon_state_s next_st;
	logic armed;
	logic tmr_run;
	logic tmr_done;
	logic [`SDM_DELAY_W-1:0] delay_ms;
	logic signed [`SDM_POS_W:0] dev;
	logic over;
	logic release_ok;

	// Distance moved in the forbidden direction; counter wrap is not handled
	function automatic logic signed [`SDM_POS_W:0] forbidden_dev(
		input logic signed [`SDM_POS_W-1:0] trail,
		input logic signed [`SDM_POS_W-1:0] pos,
		input logic positive
	);
		logic signed [`SDM_POS_W:0] d;
		d = {pos[`SDM_POS_W-1], pos} - {trail[`SDM_POS_W-1], trail};
		forbidden_dev = positive ? -d : d;
	endfunction : forbidden_dev

	// Level at or below which a latched violation may release
	function automatic logic [`SDM_WIN_W-1:0] release_limit(input cfg_s c);
		if (c.hyst_en && c.hyst <= c.window) begin
			release_limit = c.window - c.hyst;
		end else begin
			release_limit = c.window;
		end
	endfunction : release_limit

	// Only the second sync stage is read
	assign armed = cfg_i.permanent || !st.arm_sync[1];
	assign delay_ms = (cfg_i.delay_ms > `SDM_DELAY_MS_MAX) ? `SDM_DELAY_MS_MAX : cfg_i.delay_ms;
	assign tmr_run = (st.phase == PH_DELAY) && armed;

	ms_delay_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_delay (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(tmr_run),
		.delay_ms_i(delay_ms),
		.done_o(tmr_done)
	);

	// Rising count is clockwise, so positive permits counting up
	assign dev = forbidden_dev(st.trail_pos, pos_i, cfg_i.dir_positive);
	assign over = dev > $signed({2'b00, cfg_i.window});
	assign release_ok = dev <= $signed({2'b00, release_limit(cfg_i)});

	always_comb begin
		next_st = st;
		next_st.arm_sync = {st.arm_sync[0], arm_input_low_i};
		case (st.phase)
			PH_IDLE: begin
				next_st.viol = 1'b0;
				next_st.estop = 1'b0;
				if (armed) begin
					if (cfg_i.permanent) begin
						next_st.phase = PH_MONITOR;
						next_st.trail_pos = pos_i;
					end else begin
						next_st.phase = PH_DELAY;
					end
				end
			end
			PH_DELAY: begin
				if (!armed) begin
					next_st.phase = PH_IDLE;
				end else if (tmr_done) begin
					next_st.phase = PH_MONITOR;
					next_st.trail_pos = pos_i;
					next_st.viol = 1'b0;
				end
			end
			PH_MONITOR: begin
				if (!armed) begin
					next_st.phase = PH_IDLE;
					next_st.viol = 1'b0;
					next_st.estop = 1'b0;
				end else begin
					// Reference follows permitted motion only
					if (dev < 0) begin
						next_st.trail_pos = pos_i;
					end
					if (over) begin
						next_st.viol = 1'b1;
						if (!cfg_i.monitor_only) begin
							next_st.estop = 1'b1;
						end
					end else if (release_ok) begin
						next_st.viol = 1'b0;
					end
				end
			end
			default: begin
				next_st.phase = PH_IDLE;
			end
		endcase
		// Estop keeps ack low too, so a cleared violation cannot mask it
		next_st.ack = (next_st.phase == PH_MONITOR) && !next_st.viol && !next_st.estop;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st.arm_sync <= `SDM_ARM_OFF;
			st.phase <= PH_IDLE;
			st.trail_pos <= `SDM_POS_ZERO;
			st.viol <= 1'b0;
			st.estop <= 1'b0;
			st.ack <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign dir_ack_o = st.ack;
	assign estop_ramp_request_o = st.estop;
	assign status_o.monitoring = (st.phase == PH_MONITOR);
	assign status_o.violation = st.viol;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_ARM_HIGH_OFF: assert property (
		!cfg_i.permanent && st.arm_sync[1] |=> st.phase == PH_IDLE && !dir_ack_o)
		else $error("monitor stayed active with arm input high");

	AST_PERMANENT_NO_DELAY: assert property (
		cfg_i.permanent && st.phase == PH_IDLE |=> st.phase == PH_MONITOR)
		else $error("permanent mode did not start monitoring at once");

	AST_DELAY_HOLDS: assert property (
		st.phase == PH_DELAY && !tmr_done |=> st.phase != PH_MONITOR)
		else $error("monitoring started before delay elapsed");

	AST_ACK_ONLY_MONITORING: assert property (
		dir_ack_o |-> st.phase == PH_MONITOR)
		else $error("acknowledge high outside monitoring");

	AST_START_LOADS_REF: assert property (
		st.phase == PH_DELAY && tmr_done && armed
		|=> st.phase == PH_MONITOR && st.trail_pos == $past(pos_i) && !st.viol && dir_ack_o)
		else $error("monitoring start did not load reference");

	AST_TRAILS: assert property (
		st.phase == PH_MONITOR && armed && dev < 0 |=> st.trail_pos == $past(pos_i))
		else $error("reference did not trail permitted motion");

	AST_HOLDS_REF: assert property (
		st.phase == PH_MONITOR && armed && dev >= 0 |=> $stable(st.trail_pos))
		else $error("reference moved on forbidden motion");

	AST_VIOL_NORMAL: assert property (
		st.phase == PH_MONITOR && armed && over && !cfg_i.monitor_only
		|=> estop_ramp_request_o && !dir_ack_o && status_o.violation)
		else $error("normal variant violation without stop request");

	AST_VIOL_MON_ONLY: assert property (
		st.phase == PH_MONITOR && armed && over && cfg_i.monitor_only && !estop_ramp_request_o
		|=> !estop_ramp_request_o && !dir_ack_o)
		else $error("monitor-only variant raised stop request");

	AST_ACK_WITHIN: assert property (
		st.phase == PH_MONITOR && armed && !over && !st.viol && !st.estop |=> dir_ack_o)
		else $error("acknowledge low while within limits");

	AST_ESTOP_STICKY: assert property (
		estop_ramp_request_o && armed |=> estop_ramp_request_o)
		else $error("stop request dropped while still armed");

	AST_HYST_HOLD: assert property (
		st.viol && st.phase == PH_MONITOR && armed && !over && !release_ok |=> st.viol)
		else $error("violation released inside hysteresis band");

	AST_IDLE_TO_DELAY: assert property (
		!cfg_i.permanent && st.phase == PH_IDLE && armed
		|=> st.phase == PH_DELAY && !dir_ack_o)
		else $error("armed start skipped the delay phase");

	AST_PERMANENT_IGNORES_ARM: assert property (
		cfg_i.permanent && st.phase == PH_MONITOR
		|=> st.phase == PH_MONITOR)
		else $error("permanent mode left monitoring");

	AST_PERMANENT_LOADS_REF: assert property (
		cfg_i.permanent && st.phase == PH_IDLE
		|=> st.trail_pos == $past(pos_i) && dir_ack_o)
		else $error("permanent start did not load reference");

	AST_MONITOR_STAYS: assert property (
		st.phase == PH_MONITOR && armed
		|=> status_o.monitoring)
		else $error("monitoring stopped while armed");

	AST_DELAY_NO_ACK: assert property (
		st.phase == PH_DELAY
		|-> !dir_ack_o)
		else $error("acknowledge high during start delay");

	// Independent of the shared deviation function
	AST_NEG_UP_VIOLATES: assert property (
		st.phase == PH_MONITOR && armed && !cfg_i.dir_positive
		&& $signed({pos_i[`SDM_POS_W-1], pos_i}) - $signed({st.trail_pos[`SDM_POS_W-1], st.trail_pos})
		> $signed({2'b00, cfg_i.window})
		|=> status_o.violation && !dir_ack_o)
		else $error("clockwise motion beyond window not flagged");

	AST_POS_DOWN_VIOLATES: assert property (
		st.phase == PH_MONITOR && armed && cfg_i.dir_positive
		&& $signed({st.trail_pos[`SDM_POS_W-1], st.trail_pos}) - $signed({pos_i[`SDM_POS_W-1], pos_i})
		> $signed({2'b00, cfg_i.window})
		|=> status_o.violation && !dir_ack_o)
		else $error("anticlockwise motion beyond window not flagged");

	AST_NEG_DOWN_TRAILS: assert property (
		st.phase == PH_MONITOR && armed && !cfg_i.dir_positive && pos_i < st.trail_pos
		|=> st.trail_pos == $past(pos_i))
		else $error("reference did not follow negative motion");

	AST_POS_UP_TRAILS: assert property (
		st.phase == PH_MONITOR && armed && cfg_i.dir_positive && pos_i > st.trail_pos
		|=> st.trail_pos == $past(pos_i))
		else $error("reference did not follow positive motion");

	AST_WINDOW_EDGE_OK: assert property (
		st.phase == PH_MONITOR && armed && !st.viol && dev == $signed({2'b00, cfg_i.window})
		|=> !status_o.violation)
		else $error("motion equal to window flagged as violation");

	AST_VIOL_ONLY_MONITORING: assert property (
		status_o.violation
		|-> status_o.monitoring)
		else $error("violation flag outside monitoring");

	AST_ESTOP_WITH_VIOL: assert property (
		$rose(estop_ramp_request_o)
		|-> status_o.violation && !$past(cfg_i.monitor_only))
		else $error("stop request without violation");

	AST_MON_ONLY_NO_ESTOP: assert property (
		cfg_i.monitor_only && !estop_ramp_request_o
		|=> !estop_ramp_request_o)
		else $error("stop request raised in monitor-only variant");

	AST_IDLE_QUIET: assert property (
		st.phase == PH_IDLE
		|-> !dir_ack_o && !estop_ramp_request_o && !status_o.violation)
		else $error("outputs active while not activated");

	AST_ESTOP_ONLY_MONITORING: assert property (
		estop_ramp_request_o
		|-> status_o.monitoring)
		else $error("stop request outside monitoring");

	AST_RELEASE_AT_LIMIT: assert property (
		st.viol && st.phase == PH_MONITOR && armed && !over && release_ok
		|=> !st.viol)
		else $error("violation not released below release limit");

	AST_START_CLEAN: assert property (
		$rose(status_o.monitoring)
		|-> !status_o.violation && !estop_ramp_request_o)
		else $error("monitoring started with stale violation");

	AST_DISARM_CLEARS: assert property (
		st.phase == PH_MONITOR && !armed
		|=> st.phase == PH_IDLE && !estop_ramp_request_o && !status_o.violation)
		else $error("disarm did not clear stop request");

	AST_TMR_DONE_HOLDS: assert property (
		tmr_run && tmr_done
		|=> tmr_done)
		else $error("delay timer done dropped while running");

	COV_MONITOR_START: cover property (st.phase == PH_DELAY ##1 st.phase == PH_MONITOR);
	COV_ESTOP: cover property ($rose(estop_ramp_request_o));
	COV_MON_ONLY_VIOL: cover property (cfg_i.monitor_only && $rose(status_o.violation));
	COV_VIOL_RELEASE: cover property ($fell(status_o.violation) && status_o.monitoring);
	COV_PERMANENT_START: cover property (cfg_i.permanent && $rose(status_o.monitoring));

endmodule : safe_direction_monitor

// ==== hw/sdm_cfg.svh ====
// Constants for the safe direction monitor
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH

`define SDM_CLK_HZ 50000000
`define SDM_MS_PER_S 1000
`define SDM_PRESC_W 16
`define SDM_DELAY_W 17
`define SDM_POS_W 32
`define SDM_WIN_W 31
`define SDM_DELAY_MS_MAX 17'h1_D4C0
`define SDM_DELAY_MS_DEF 17'h0_0014
`define SDM_WINDOW_DEF 31'h0000_0064
`define SDM_ARM_OFF 2'h3
`define SDM_POS_ZERO 32'h0000_0000
`define SDM_PRESC_ZERO 16'h0000
`define SDM_PRESC_ONE 16'h0001
`define SDM_MS_ZERO 17'h0_0000
`define SDM_MS_ONE 17'h0_0001

`endif
